// >>> common/arp_pkg.sv
// Package: constants for the converter result output port
package arp_pkg;
  localparam int RES_W = 16;
  localparam int CNT_W = 5;
  localparam int HI_LSB = 12;
  localparam logic [15:0] SIGN_MASK = 16'h8000;
  localparam logic [4:0] BITS_PER_WORD = 5'h10;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam int CLK_MHZ = 100;
  localparam int MCLK_DIV_NS = 40;
  localparam int MCLK_HALF = (MCLK_DIV_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] MCLK_HALF_CYC = 8'(MCLK_HALF);
endpackage : arp_pkg

// >>> logic/arp_sync2.sv
// Two-flop synchroniser for a level
`timescale 1ns/1ps
module arp_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : arp_sync2

// >>> logic/arp_slave_shift.sv
// Slave-mode shifter on the host bit clock
`timescale 1ns/1ps
module arp_slave_shift (
  input wire logic sclk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic invert,
  input wire logic [15:0] word,
  input wire logic chain_in,
  output logic sdo,
  output logic done_tog,
  output logic start_tog
);
  // Rising edge of the effective clock; inversion XORs sclk with invert, same path
  logic eclk;
  logic [15:0] sh_ff;
  logic [4:0] cnt_ff;
  assign eclk = sclk ^ invert;
  // Clock gated by chip select: no edge counts while cs_n high
  always_ff @(posedge eclk or posedge cs_n or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= arp_pkg::CNT_ZERO;
    end else if (cs_n) begin
      cnt_ff <= arp_pkg::CNT_ZERO;
    end else if (cnt_ff != arp_pkg::BITS_PER_WORD) begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end
  // First edge loads the word behind the MSB already shown
  always_ff @(posedge eclk) begin
    if (!cs_n) begin
      if (cnt_ff == arp_pkg::CNT_ZERO) begin
        sh_ff <= {word[14:0], chain_in};
      end else begin
        sh_ff <= {sh_ff[14:0], chain_in};
      end
    end
  end
  assign sdo = (cnt_ff == arp_pkg::CNT_ZERO) ? word[15] : sh_ff[15];
  // Start and end of a read, as toggles for the system clock side
  always_ff @(posedge eclk or negedge resetn) begin
    if (!resetn) begin
      start_tog <= 1'b0;
      done_tog <= 1'b0;
    end else if (!cs_n) begin
      if (cnt_ff == arp_pkg::CNT_ZERO) begin
        start_tog <= ~start_tog;
      end
      if (cnt_ff == arp_pkg::BITS_PER_WORD - 5'h01) begin
        done_tog <= ~done_tog;
      end
    end
  end
endmodule : arp_slave_shift

// >>> logic/arp_result_port.sv
// Result output port: parallel bus, serial master and serial slave
`timescale 1ns/1ps
// Overview of operation
// - Select low drives 16-bit result on parallel pins, bit per pin.
// - Select high floats parallel bits 12 to 15.
// - Serial mode shifts stored result out MSB first.
// - Coding select chooses offset binary or twos complement.
// - Internal clock, no inversion: each serial bit changes on falling edge, stable at rising edge.
// - External clock, no inversion: data changes on rising edge.
// - External clock, inverted: data changes on falling edge.
// - Bit clock pin output in master mode, input in slave mode.
// - Frame sync is driven only with the internal bit clock.
// - Frame sync polarity low: sync high while serial data valid.
// - Frame sync polarity high: sync low while serial data valid.
// - Slave read unfinished at next conversion end: latch new result anyway, pulse flag.
// - Busy rises when a conversion starts.
// - Busy falls when result latched into result register.
// - Parallel data drivers enabled only while chip select and read low.
// - Slave mode ignores external bit clock while chip select high.
// - High reset input clears busy and the master serial engine, aborts conversion.
// - Clock source low selects master, high selects slave.
// - Master read mode high outputs previous result during conversion.
// - Slave mode passes chain input through, sixteen clocks later.
module arp_result_port (
  input wire logic clk,
  input wire logic resetn,
  input wire logic conv_reset,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [15:0] conv_result,
  input wire logic serial_parallel_select,
  input wire logic clock_source_select,
  input wire logic bit_clock_invert,
  input wire logic frame_sync_polarity,
  input wire logic output_coding_select,
  input wire logic read_mode_or_chain_input,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic sclk_in,
  output logic [15:0] data_out,
  output logic [15:0] data_oe_n,
  output logic serial_result_out,
  output logic sclk_out,
  output logic sclk_oe_n,
  output logic frame_sync,
  output logic incomplete_read_flag,
  output logic busy,
  output logic conv_abort
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [7:0] pins_s;
  logic ser_s, slave_s, inv_s, fpol_s, ocs_s, rdc_s, cs_s, rd_s;
  arp_sync2 #(.W(8)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({serial_parallel_select, clock_source_select, bit_clock_invert,
        frame_sync_polarity, output_coding_select, read_mode_or_chain_input,
        cs_n, rd_n}),
    .q(pins_s)
  );
  assign {ser_s, slave_s, inv_s, fpol_s, ocs_s, rdc_s, cs_s, rd_s} = pins_s;
  logic rd_en;
  assign rd_en = !cs_s && !rd_s;
  ////////////////////////////////////////////////////////////////////////////
  // Result latch and busy
  logic [15:0] word_ff;
  logic busy_ff, abort_ff, load_tog_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
      abort_ff <= 1'b0;
      word_ff <= '0;
      load_tog_ff <= 1'b0;
    end else begin
      abort_ff <= conv_reset;
      if (conv_reset) begin
        busy_ff <= 1'b0;
      end else if (conv_start) begin
        busy_ff <= 1'b1;
      end else if (conv_done && busy_ff) begin
        busy_ff <= 1'b0;
      end
      if (conv_done && busy_ff && !conv_reset) begin
        word_ff <= ocs_s ? conv_result : conv_result ^ arp_pkg::SIGN_MASK;
        load_tog_ff <= ~load_tog_ff;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Master serial engine
  logic [15:0] msh_ff;
  logic [4:0] mcnt_ff;
  logic [7:0] div_ff;
  logic mclk_ff, mact_ff, mdone_ff;
  logic m_ok;
  assign m_ok = ser_s && !slave_s && rd_en && !mact_ff && !mdone_ff
                && (rdc_s || !busy_ff);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      msh_ff <= '0;
      mcnt_ff <= arp_pkg::CNT_ZERO;
      div_ff <= '0;
      mclk_ff <= 1'b0;
      mact_ff <= 1'b0;
      mdone_ff <= 1'b0;
    end else if (conv_reset || !rd_en || slave_s) begin
      mact_ff <= 1'b0;
      mclk_ff <= 1'b0;
      mcnt_ff <= arp_pkg::CNT_ZERO;
      mdone_ff <= 1'b0;
    end else if (m_ok) begin
      msh_ff <= word_ff;
      mact_ff <= 1'b1;
      div_ff <= '0;
    end else if (mact_ff) begin
      if (div_ff == arp_pkg::MCLK_HALF_CYC - 8'h01) begin
        div_ff <= '0;
        mclk_ff <= ~mclk_ff;
        // Data moves with the falling edge, so the rising edge sees it stable
        if (mclk_ff) begin
          msh_ff <= {msh_ff[14:0], 1'b0};
          mcnt_ff <= mcnt_ff + 5'h01;
          if (mcnt_ff == arp_pkg::BITS_PER_WORD - 5'h01) begin
            mact_ff <= 1'b0;
            mdone_ff <= 1'b1;
          end
        end
      end else begin
        div_ff <= div_ff + 8'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Slave serial engine on the host clock
  logic s_sdo, s_done_tog, s_start_tog;
  arp_slave_shift u_slave (
    .sclk(sclk_in),
    .resetn(resetn),
    .cs_n(cs_n),
    .invert(bit_clock_invert),
    .word(word_ff),
    .chain_in(read_mode_or_chain_input),
    .sdo(s_sdo),
    .done_tog(s_done_tog),
    .start_tog(s_start_tog)
  );
  logic [1:0] tog_s;
  arp_sync2 #(.W(2)) u_tsync (
    .clk(clk),
    .resetn(resetn),
    .d({s_done_tog, s_start_tog}),
    .q(tog_s)
  );
  logic done_seen_ff, start_seen_ff, reading_ff, err_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_seen_ff <= 1'b0;
      start_seen_ff <= 1'b0;
      reading_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      done_seen_ff <= tog_s[1];
      start_seen_ff <= tog_s[0];
      err_ff <= 1'b0;
      if (tog_s[0] != start_seen_ff) begin
        reading_ff <= 1'b1;
      end else if (tog_s[1] != done_seen_ff) begin
        reading_ff <= 1'b0;
      end
      if (reading_ff && conv_done && busy_ff && slave_s && ser_s) begin
        err_ff <= 1'b1;
        reading_ff <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  logic [15:0] nxt_oe_n;
  always_comb begin
    nxt_oe_n = '1;
    if (rd_en) begin
      nxt_oe_n = '0;
      if (ser_s) begin
        nxt_oe_n[15:arp_pkg::HI_LSB] = 4'hF;
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_out <= '0;
      data_oe_n <= '1;
      serial_result_out <= 1'b0;
      sclk_out <= 1'b0;
      sclk_oe_n <= 1'b1;
      frame_sync <= 1'b0;
      incomplete_read_flag <= 1'b0;
      busy <= 1'b0;
      conv_abort <= 1'b0;
    end else begin
      data_out <= ser_s ? '0 : word_ff;
      data_oe_n <= nxt_oe_n;
      serial_result_out <= slave_s ? s_sdo : msh_ff[15];
      sclk_out <= mclk_ff ^ inv_s;
      sclk_oe_n <= !(ser_s && !slave_s);
      frame_sync <= (ser_s && !slave_s) ? (mact_ff ^ fpol_s) : 1'b0;
      incomplete_read_flag <= err_ff;
      busy <= busy_ff;
      conv_abort <= abort_ff;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_busy_rise: assert property (@(posedge clk) disable iff (!resetn)
    conv_start && !conv_reset |=> busy_ff) else $error("busy not set");
  chk_busy_fall: assert property (@(posedge clk) disable iff (!resetn)
    $fell(busy_ff) && !$past(conv_reset) |-> $changed(load_tog_ff))
    else $error("busy fell without latch");
  chk_abort_busy: assert property (@(posedge clk) disable iff (!resetn)
    conv_reset |=> !busy_ff ##1 !busy) else $error("abort failed");
  chk_oe_read: assert property (@(posedge clk) disable iff (!resetn)
    !rd_en |=> &data_oe_n) else $error("driver on without read");
  chk_hi_float: assert property (@(posedge clk) disable iff (!resetn)
    ser_s |=> &data_oe_n[15:12]) else $error("high bits driven");
  chk_sync_slave: assert property (@(posedge clk) disable iff (!resetn)
    slave_s |=> !frame_sync) else $error("sync in slave mode");
  chk_sclk_dir: assert property (@(posedge clk) disable iff (!resetn)
    ser_s && slave_s |=> sclk_oe_n) else $error("sclk driven in slave");
  chk_err_pulse: assert property (@(posedge clk) disable iff (!resetn)
    err_ff |=> !err_ff) else $error("error not a pulse");
  chk_sync_valid: assert property (@(posedge clk) disable iff (!resetn)
    ser_s && !slave_s && mact_ff |=> frame_sync == !fpol_s)
    else $error("sync level wrong");
  cov_master: cover property (@(posedge clk) disable iff (!resetn)
    mdone_ff);
  cov_err: cover property (@(posedge clk) disable iff (!resetn) err_ff);
  cov_conv: cover property (@(posedge clk) disable iff (!resetn)
    $fell(busy_ff));
endmodule : arp_result_port

// >>> tb/arp_host_model.sv
// Host model that reads results from the port
`timescale 1ns/1ps
module arp_host_model (
  input wire logic clk,
  input wire logic serial_parallel_select,
  input wire logic clock_source_select,
  input wire logic bit_clock_invert,
  input wire logic frame_sync_polarity,
  input wire logic [4:0] nbits,
  input wire logic go,
  input wire logic sclk_out,
  input wire logic frame_sync,
  input wire logic [15:0] data_out,
  input wire logic serial_result_out,
  output logic cs_n,
  output logic rd_n,
  output logic sclk_in,
  output logic [15:0] word,
  output logic got
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    sclk_in = 1'b1;
    word = 16'h0000;
    got = 1'b0;
  end
  always @(bit_clock_invert) begin
    if (cs_n) sclk_in = ~bit_clock_invert;
  end
  always @(posedge go) begin
    sclk_in = ~bit_clock_invert;
    cs_n = 1'b0;
    rd_n = 1'b0;
    if (serial_parallel_select && !clock_source_select) begin
      for (int i = 0; i < 200 && frame_sync !== !frame_sync_polarity; i++)
        @(posedge clk);
      for (int i = 0; i < 16; i++) begin
        @(posedge sclk_out);
        word = {word[14:0], serial_result_out};
      end
    end else begin
      repeat (10) @(posedge clk);
      #3;
      if (!serial_parallel_select) word = data_out;
      for (int i = 0; serial_parallel_select && i < nbits; i++) begin
        #40 sclk_in = bit_clock_invert;
        word = {word[14:0], serial_result_out};
        #40 sclk_in = ~bit_clock_invert;
      end
    end
    if (nbits == 5'h10) begin
      got = 1'b1;
      #1 got = 1'b0;
    end
    wait (!go);
    cs_n = 1'b1;
    rd_n = 1'b1;
  end
endmodule : arp_host_model

// >>> tb/tb_top.sv
// Testbench for the converter result output port
`timescale 1ns/1ps
module tb_top;
  logic clk, resetn, conv_reset, conv_start, conv_done, go, got;
  logic [15:0] conv_result, data_out, data_oe_n, word;
  logic serial_parallel_select, clock_source_select, bit_clock_invert;
  logic frame_sync_polarity, output_coding_select, read_mode_or_chain_input;
  logic cs_n, rd_n, sclk_in, serial_result_out, sclk_out, sclk_oe_n;
  logic frame_sync, incomplete_read_flag, busy, conv_abort;
  logic [4:0] nbits;
  logic [15:0] exp_q[$];
  int mismatches, tests_run, flags;
  arp_result_port arp_result_port_i (.*);
  arp_host_model arp_host_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (incomplete_read_flag === 1'b1) flags++;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  always @(posedge got) begin
    check(word, exp_q.pop_front());
    if (serial_parallel_select) begin
      check(data_oe_n[15:12], 4'hF);
      check(sclk_oe_n, clock_source_select);
    end else begin
      check(data_oe_n, 16'h0000);
    end
  end
  task automatic setup(input logic s, input logic c, input logic i,
                       input logic f);
    @(negedge clk);
    serial_parallel_select = s;
    clock_source_select = c;
    bit_clock_invert = i;
    frame_sync_polarity = f;
    output_coding_select = 1'($urandom);
    read_mode_or_chain_input = 1'($urandom);
    repeat (6) @(negedge clk);
  endtask : setup
  task automatic convert(input logic [15:0] res);
    @(negedge clk) conv_start = 1'b1;
    @(negedge clk) conv_start = 1'b0;
    repeat (2) @(negedge clk);
    check(busy, 1'b1);
    conv_result = res;
    conv_done = 1'b1;
    @(negedge clk) conv_done = 1'b0;
    repeat (4) @(negedge clk);
    check(busy, 1'b0);
  endtask : convert
  task automatic read_word(input logic [15:0] raw);
    exp_q.push_back(output_coding_select ? raw : raw ^ arp_pkg::SIGN_MASK);
    nbits = 5'h10;
    @(negedge clk) go = 1'b1;
    @(negedge clk) go = 1'b0;
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(negedge clk);
    repeat (8) @(negedge clk);
    check(data_oe_n, 16'hFFFF);
    if (serial_parallel_select && !clock_source_select)
      check(frame_sync, frame_sync_polarity);
  endtask : read_word
  initial begin
    {resetn, conv_reset, conv_start, conv_done, go} = 5'h00;
    conv_result = 16'h0000;
    nbits = 5'h10;
    void'($urandom(32059));
    setup(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    check(busy, 1'b0);
    check(data_oe_n, 16'hFFFF);
    repeat (3) @(negedge clk);
    for (int m = 0; m < 6; m++) begin
      setup(m > 1, m > 3, m > 3 ? m[0] : 1'b0, m[0]);
      convert(m == 0 ? 16'h8000 : 16'($urandom));
      read_word(conv_result);
    end
    nbits = 5'h05;
    @(negedge clk) go = 1'b1;
    repeat (60) @(negedge clk);
    convert(16'h7FFF);
    check(flags, 1);
    go = 1'b0;
    @(negedge clk) conv_start = 1'b1;
    @(negedge clk) conv_start = 1'b0;
    repeat (2) @(negedge clk);
    conv_reset = 1'b1;
    repeat (4) @(negedge clk);
    check(busy, 1'b0);
    check(conv_abort, 1'b1);
    conv_reset = 1'b0;
    repeat (4) @(negedge clk);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
endmodule : tb_top
